// [rtl/gtm_dual_timer.sv]
// dual 16-bit timer core: joined 32-bit timer, rtc, or two 16-bit timers
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - reset: idle, counters and loads all ones
// - reset: prescale counters and registers zero
// - config 0 timer, 1 rtc, joined
// - config 4 splits into two timers
// - joined load write fills both halves
// - joined value read gives b:a
// - joined count uses only a mode
// - zero reloads; one-shot clears enable
// - zero sets raw flag, masked if enabled
// - trigger pulse only when trigger enabled
// - load write reloads counter next cycle
// - stall bit freezes counter until cleared
// - rtc counts up, first load one
// - rtc input divided to one hertz
// - rtc match rolls counter to zero
// - rtc match sets raw, masked flags
// - rtc enable bit overrides stall bits
// - split mode: 16-bit with 8-bit prescale
// - split zero reloads load and prescale
// - split zero sets own flags, trigger
// - prescale p gives p plus one clocks
module gtm_dual_timer
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // register port
    input  wire logic [gtm_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    output      logic [31:0]                rdata,
    // rtc slow clock pin
    input  wire logic                       capture_pin_a0,
    // events
    output      logic                       adc_trigger,
    output      logic                       irq
);
    import gtm_pkg::*;

    typedef struct packed {
        logic [2:0]        cfg;
        logic [1:0][1:0]   mode;
        logic [1:0]        en;
        logic [1:0]        stall;
        logic [1:0]        ote;
        logic              rtc_en;
        logic [INT_W-1:0]  imr;
        logic [INT_W-1:0]  ris;
        logic [1:0][15:0]  ilr;
        logic [1:0][15:0]  cnt;
        logic [1:0][7:0]   pr;
        logic [1:0][7:0]   pcnt;
        logic [31:0]       match;
        logic [31:0]       rdata;
        logic              trig;
        logic              irq;
    } gtm_state_type;

    gtm_state_type r;
    gtm_state_type next_r;

    logic              rtc_tick;
    logic              rtc_run;
    logic              is_t32;
    logic              is_rtc;
    logic              is_16;
    logic              rtc_frozen;

    // timeout status bit of counter i
    function automatic logic [INT_W-1:0] to_mask(input int i);
        logic [INT_W-1:0] m;
        m = '0;
        if (i == 0) begin
            m[INT_A_TO] = 1'b1;
        end else begin
            m[INT_B_TO] = 1'b1;
        end
        return m;
    endfunction

    // count value as seen by software; joined modes show b:a
    function automatic logic [31:0] joined_word(input logic split,
                                                input logic [15:0] hi,
                                                input logic [15:0] lo);
        return split ? {16'h0000, lo} : {hi, lo};
    endfunction

    // operating mode decode
    assign is_t32     = (r.cfg == CFG_32_TIMER);
    assign is_rtc     = (r.cfg == CFG_32_RTC);
    assign is_16      = (r.cfg == CFG_16);
    // stall bits hold the rtc only while the override bit is clear
    assign rtc_frozen = (r.stall[0] | r.stall[1]) & ~r.rtc_en;
    assign rtc_run    = is_rtc & r.en[0] & ~rtc_frozen;

    gtm_rtc_div u_rtc_div (
        .clk            (clk),
        .srst           (srst),
        .run            (rtc_run),
        .capture_pin_a0 (capture_pin_a0),
        .tick           (rtc_tick)
    );

    // counting, then register writes, then status merge
    always_comb begin
        logic [31:0]      c32;
        logic [INT_W-1:0] set_ev;
        logic [INT_W-1:0] clr;
        logic             trig_ev;
        next_r       = r;
        next_r.rdata = 32'h0000_0000;
        c32          = {r.cnt[1], r.cnt[0]};
        set_ev       = '0;
        clr          = '0;
        trig_ev      = 1'b0;

        // joined down-counter; b's mode field is never looked at
        if (is_t32 && r.en[0] && !r.stall[0]) begin
            if (c32 == 32'h0000_0000) begin
                {next_r.cnt[1], next_r.cnt[0]} = {r.ilr[1], r.ilr[0]};
                set_ev  = set_ev | to_mask(0);
                trig_ev = r.ote[0];
                if (r.mode[0] == MODE_ONESHOT) begin
                    next_r.en[0] = 1'b0;
                end
            end else begin
                {next_r.cnt[1], next_r.cnt[0]} = c32 - 32'h0000_0001;
            end
        end

        // joined up-counter on the one hertz tick
        if (is_rtc && r.en[0] && rtc_tick && !rtc_frozen) begin
            if (c32 == r.match) begin
                {next_r.cnt[1], next_r.cnt[0]} = RTC_ROLLOVER;
                set_ev = set_ev | (INT_W'(1) << INT_RTC);
            end else begin
                {next_r.cnt[1], next_r.cnt[0]} = c32 + 32'h0000_0001;
            end
        end

        // two independent prescaled down-counters
        for (int i = 0; i < 2; i++) begin
            if (is_16 && r.en[i] && !r.stall[i]) begin
                if (r.pcnt[i] != 8'h00) begin
                    next_r.pcnt[i] = r.pcnt[i] - 8'h01;
                end else begin
                    next_r.pcnt[i] = r.pr[i];
                    if (r.cnt[i] == 16'h0000) begin
                        next_r.cnt[i] = r.ilr[i];
                        set_ev  = set_ev | to_mask(i);
                        trig_ev = trig_ev | r.ote[i];
                        if (r.mode[i] == MODE_ONESHOT) begin
                            next_r.en[i] = 1'b0;
                        end
                    end else begin
                        next_r.cnt[i] = r.cnt[i] - 16'h0001;
                    end
                end
            end
        end

        // register writes take priority over the count step
        if (wr_stb) begin
            if (addr == OFF_CFG) begin
                next_r.cfg = wdata[2:0];
                if (wdata[2:0] == CFG_32_RTC && r.cfg != CFG_32_RTC) begin
                    {next_r.cnt[1], next_r.cnt[0]} = RTC_FIRST_LOAD;
                end
            end else if (addr == OFF_A_MODE) begin
                next_r.mode[0] = wdata[1:0];
            end else if (addr == OFF_B_MODE) begin
                next_r.mode[1] = wdata[1:0];
            end else if (addr == OFF_CTL) begin
                next_r.en[0]   = wdata[CTL_A_EN];
                next_r.stall[0] = wdata[CTL_A_STALL];
                next_r.rtc_en  = wdata[CTL_RTC_EN];
                next_r.ote[0]  = wdata[CTL_A_OTE];
                next_r.en[1]   = wdata[CTL_B_EN];
                next_r.stall[1] = wdata[CTL_B_STALL];
                next_r.ote[1]  = wdata[CTL_B_OTE];
            end else if (addr == OFF_IMR) begin
                next_r.imr = wdata[INT_W-1:0] & INT_USED;
            end else if (addr == OFF_ICR) begin
                clr = wdata[INT_W-1:0] & INT_USED;
            end else if (addr == OFF_A_ILR) begin
                // the counter follows the new load at once
                next_r.ilr[0]  = wdata[15:0];
                next_r.cnt[0]  = wdata[15:0];
                next_r.pcnt[0] = r.pr[0];
                if (!is_16) begin
                    next_r.ilr[1] = wdata[31:16];
                    next_r.cnt[1] = wdata[31:16];
                end
            end else if (addr == OFF_B_ILR) begin
                next_r.ilr[1]  = wdata[15:0];
                next_r.cnt[1]  = wdata[15:0];
                next_r.pcnt[1] = r.pr[1];
            end else if (addr == OFF_A_MATCH) begin
                next_r.match = wdata;
            end else if (addr == OFF_A_PR) begin
                next_r.pr[0] = wdata[7:0];
            end else if (addr == OFF_B_PR) begin
                next_r.pr[1] = wdata[7:0];
            end
        end

        // register reads; data stands in the following cycle only
        if (rd_stb) begin
            if (addr == OFF_CFG) begin
                next_r.rdata = {29'h0, r.cfg};
            end else if (addr == OFF_A_MODE) begin
                next_r.rdata = {30'h0, r.mode[0]};
            end else if (addr == OFF_B_MODE) begin
                next_r.rdata = {30'h0, r.mode[1]};
            end else if (addr == OFF_CTL) begin
                next_r.rdata[CTL_A_EN]    = r.en[0];
                next_r.rdata[CTL_A_STALL] = r.stall[0];
                next_r.rdata[CTL_RTC_EN]  = r.rtc_en;
                next_r.rdata[CTL_A_OTE]   = r.ote[0];
                next_r.rdata[CTL_B_EN]    = r.en[1];
                next_r.rdata[CTL_B_STALL] = r.stall[1];
                next_r.rdata[CTL_B_OTE]   = r.ote[1];
            end else if (addr == OFF_IMR) begin
                next_r.rdata = {23'h0, r.imr};
            end else if (addr == OFF_RIS) begin
                next_r.rdata = {23'h0, r.ris};
            end else if (addr == OFF_MIS) begin
                next_r.rdata = {23'h0, r.ris & r.imr};
            end else if (addr == OFF_A_ILR) begin
                next_r.rdata = joined_word(is_16, r.ilr[1], r.ilr[0]);
            end else if (addr == OFF_B_ILR) begin
                next_r.rdata = {16'h0000, r.ilr[1]};
            end else if (addr == OFF_A_MATCH) begin
                next_r.rdata = r.match;
            end else if (addr == OFF_A_PR) begin
                next_r.rdata = {24'h0, r.pr[0]};
            end else if (addr == OFF_B_PR) begin
                next_r.rdata = {24'h0, r.pr[1]};
            end else if (addr == OFF_A_VALUE) begin
                next_r.rdata = joined_word(is_16, r.cnt[1], r.cnt[0]);
            end else if (addr == OFF_B_VALUE) begin
                next_r.rdata = {16'h0000, r.cnt[1]};
            end
        end

        // a new event wins over a clear in the same cycle
        next_r.ris  = (r.ris & ~clr) | set_ev;
        next_r.trig = trig_ev;
        next_r.irq  = |(next_r.ris & next_r.imr);
    end

    // state register; reset leaves every counter idle
    always_ff @(posedge clk) begin
        if (srst) begin
            r       <= '0;
            r.cfg   <= CFG_RESET;
            r.mode  <= {MODE_RESET, MODE_RESET};
            r.ilr   <= {ILR_RESET, ILR_RESET};
            r.cnt   <= {CNT_RESET, CNT_RESET};
            r.pr    <= {PR_RESET, PR_RESET};
            r.pcnt  <= {PR_RESET, PR_RESET};
            r.match <= MATCH_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign rdata       = r.rdata;
    assign adc_trigger = r.trig;
    assign irq         = r.irq;
endmodule

// [rtl/gtm_pkg.sv]
// constants shared by the dual timer core and its rtc divider
package gtm_pkg;
    // register bus
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] OFF_CFG         = 8'h00;
    localparam logic [7:0] OFF_A_MODE      = 8'h04;
    localparam logic [7:0] OFF_B_MODE      = 8'h08;
    localparam logic [7:0] OFF_CTL         = 8'h0C;
    localparam logic [7:0] OFF_IMR         = 8'h18;
    localparam logic [7:0] OFF_RIS         = 8'h1C;
    localparam logic [7:0] OFF_MIS         = 8'h20;
    localparam logic [7:0] OFF_ICR         = 8'h24;
    localparam logic [7:0] OFF_A_ILR       = 8'h28;
    localparam logic [7:0] OFF_B_ILR       = 8'h2C;
    localparam logic [7:0] OFF_A_MATCH     = 8'h30;
    localparam logic [7:0] OFF_A_PR        = 8'h38;
    localparam logic [7:0] OFF_B_PR        = 8'h3C;
    localparam logic [7:0] OFF_A_VALUE     = 8'h48;
    localparam logic [7:0] OFF_B_VALUE     = 8'h4C;
    // configuration values
    localparam logic [2:0] CFG_32_TIMER    = 3'h0;
    localparam logic [2:0] CFG_32_RTC      = 3'h1;
    localparam logic [2:0] CFG_16          = 3'h4;
    localparam logic [2:0] CFG_RESET       = 3'h0;
    // mode field values
    localparam logic [1:0] MODE_ONESHOT    = 2'h1;
    localparam logic [1:0] MODE_PERIODIC   = 2'h2;
    localparam logic [1:0] MODE_RESET      = 2'h0;
    // control register bit positions
    localparam int         CTL_A_EN        = 0;
    localparam int         CTL_A_STALL     = 1;
    localparam int         CTL_RTC_EN      = 4;
    localparam int         CTL_A_OTE       = 5;
    localparam int         CTL_B_EN        = 8;
    localparam int         CTL_B_STALL     = 9;
    localparam int         CTL_B_OTE       = 13;
    // interrupt status bit positions
    localparam int         INT_W           = 9;
    localparam int         INT_A_TO        = 0;
    localparam int         INT_RTC         = 3;
    localparam int         INT_B_TO        = 8;
    localparam logic [8:0] INT_USED        = 9'h109;
    // reset values and rtc load values
    localparam logic [15:0] CNT_RESET      = 16'hFFFF;
    localparam logic [15:0] ILR_RESET      = 16'hFFFF;
    localparam logic [7:0]  PR_RESET       = 8'h00;
    localparam logic [31:0] MATCH_RESET    = 32'hFFFF_FFFF;
    localparam logic [31:0] RTC_FIRST_LOAD = 32'h0000_0001;
    localparam logic [31:0] RTC_ROLLOVER   = 32'h0000_0000;
    // rtc input division: 32.768 kHz down to 1 Hz
    localparam int          RTC_IN_HZ      = 32768;
    localparam int          RTC_OUT_HZ     = 1;
    localparam int          RTC_DIV        = RTC_IN_HZ / RTC_OUT_HZ;
    localparam int          RTC_DIV_W      = 15;
    localparam logic [14:0] RTC_DIV_LAST   = 15'(RTC_DIV - 1);
endpackage

// [rtl/gtm_rtc_div.sv]
// rtc input synchroniser and divider: one tick per RTC_DIV rising input edges
`timescale 1ns/1ps
module gtm_rtc_div
    import gtm_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // control
    input  wire logic run,
    // slow clock pin
    input  wire logic capture_pin_a0,
    // one-cycle tick
    output      logic tick
);
    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic                 prev;
        logic [RTC_DIV_W-1:0] cnt;
        logic                 tick;
    } gtm_div_state_type;

    gtm_div_state_type r;
    gtm_div_state_type next_r;

    // count rising edges of the synchronised pin while running
    always_comb begin
        next_r       = r;
        next_r.sync1 = capture_pin_a0;
        next_r.sync2 = r.sync1;
        next_r.prev  = r.sync2;
        next_r.tick  = 1'b0;
        if (!run) begin
            next_r.cnt = '0; // a fresh start counts a full second
        end else if (r.sync2 && !r.prev) begin
            if (r.cnt == RTC_DIV_LAST) begin
                next_r.cnt  = '0;
                next_r.tick = 1'b1;
            end else begin
                next_r.cnt = r.cnt + 15'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

// [verif/gtm_dual_timer_checker.sv]
// port-level assertions for the dual timer core
`timescale 1ns/1ps
module gtm_dual_timer_checker
    import gtm_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // register port
    input  wire logic [gtm_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    input  wire logic [31:0]                rdata,
    // rtc pin and events
    input  wire logic                       capture_pin_a0,
    input  wire logic                       adc_trigger,
    input  wire logic                       irq
);
    logic       ote_q;
    logic [8:0] mask_q;
    logic       split_q;

    // shadows of software-owned bits; hardware never alters them
    always_ff @(posedge clk) begin
        if (srst) begin
            ote_q   <= 1'b0;
            mask_q  <= 9'h000;
            split_q <= 1'b0;
        end else if (wr_stb && addr == OFF_CFG) begin
            split_q <= (wdata[2:0] == CFG_16);
        end else if (wr_stb && addr == OFF_CTL) begin
            ote_q <= wdata[CTL_A_OTE] | wdata[CTL_B_OTE];
        end else if (wr_stb && addr == OFF_IMR) begin
            mask_q <= wdata[8:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_reset_quiet: assert property (
        $fell(srst) |-> rdata == 32'h0 && !adc_trigger && !irq)
        else $error("outputs not quiet after reset");
    chk_read_idle: assert property (
        !$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_load_echo: assert property (
        !split_q && wr_stb && addr == OFF_A_ILR
        ##1 rd_stb && addr == OFF_A_ILR
        |=> rdata == $past(wdata, 2))
        else $error("joined load not stored whole");
    chk_trig_gate: assert property (
        adc_trigger |-> $past(ote_q))
        else $error("trigger without trigger enable");
    chk_trig_pulse: assert property (
        adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    chk_irq_mask: assert property (
        irq |-> (mask_q & INT_USED) != 9'h000)
        else $error("interrupt with every source masked");
    chk_irq_hold: assert property (
        irq && !wr_stb |=> irq)
        else $error("interrupt dropped without a write");
    chk_irq_clear: assert property (
        wr_stb && addr == OFF_ICR && wdata[8:0] == INT_USED |=> !irq)
        else $error("interrupt survived a full clear");

    cover_irq: cover property ($rose(irq));
    cover_trig: cover property (adc_trigger);
    cover_echo: cover property (wr_stb ##1 rd_stb ##1 rdata != 32'h0);
endmodule

bind gtm_dual_timer gtm_dual_timer_checker u_chk (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .capture_pin_a0(capture_pin_a0), .adc_trigger(adc_trigger),
    .irq(irq)
);

// [verif/gtm_dual_timer_tb.sv]
// self-checking testbench for the dual timer core
`timescale 1ns/1ps
module gtm_dual_timer_tb;
    import gtm_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        capture_pin_a0 = 1'b0;
    logic        rtc_drive = 1'b0;
    logic [31:0] rdata;
    logic        adc_trigger;
    logic        irq;
    int          mismatches = 0;
    int          compares = 0;
    int          cyc = 0;
    int          trig_cnt = 0;
    int          trig_last = 0;
    int          trig_gap = 0;
    int          n;

    always #5 clk = ~clk;

    // slow rtc input; only edges are counted, so a fast pin keeps it short
    always @(posedge clk) begin
        if (rtc_drive) begin
            capture_pin_a0 <= ~capture_pin_a0;
        end
    end

    gtm_dual_timer dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .capture_pin_a0(capture_pin_a0), .adc_trigger(adc_trigger),
        .irq(irq)
    );

    // trigger monitor: counts pulses and the spacing of the last two
    always @(posedge clk) begin
        cyc++;
        if (adc_trigger === 1'b1) begin
            trig_cnt++;
            trig_gap = cyc - trig_last;
            trig_last = cyc;
        end
    end

    // one bus cycle; both strobes set together so none is driven twice
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wdata <= d;
    endtask

    task automatic chk32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, a, 32'h0);
        @(negedge clk);
        chk32(what, exp, rdata);
    endtask

    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 8'h00, 32'h0);
    endtask

    // bounded wait, returns cycles until the interrupt line rises
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            idle(1);
            @(negedge clk);
            k++;
        end while (irq !== 1'b1 && k < 70000);
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog: one rtc second is about 65540 cycles, the rest is short
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        $display("ERROR watchdog expected finish seen timeout");
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_A_ILR, 32'hFFFF_FFFF, "a load");
        rd(OFF_A_VALUE, 32'hFFFF_FFFF, "a value");
        rd(OFF_A_PR, 32'h0, "a prescale");
        rd(OFF_B_PR, 32'h0, "b prescale");
        rd(OFF_CTL, 32'h0, "control");
        rd(OFF_RIS, 32'h0, "raw status");
        rd(8'h10, 32'h0, "unmapped");
        $display("test reset done");
        // joined load and value halves
        wr(OFF_A_ILR, 32'h1234_5678);
        rd(OFF_A_ILR, 32'h1234_5678, "joined load");
        rd(OFF_A_VALUE, 32'h1234_5678, "joined value");
        // one-shot; a periodic b mode must not matter when joined
        wr(OFF_B_MODE, {30'h0, MODE_PERIODIC});
        wr(OFF_A_MODE, {30'h0, MODE_ONESHOT});
        wr(OFF_IMR, 32'h1);
        wr(OFF_A_ILR, 32'h5);
        wr(OFF_CTL, 32'h21);
        wait_irq(n);
        chk32("oneshot delay", 32'(n), 32'd7);
        rd(OFF_CTL, 32'h20, "enable cleared");
        rd(OFF_A_VALUE, 32'h5, "reloaded");
        rd(OFF_RIS, 32'h1, "raw timeout");
        rd(OFF_MIS, 32'h1, "masked timeout");
        chk32("triggers", 32'(trig_cnt), 32'd1);
        wr(OFF_ICR, {23'h0, INT_USED});
        rd(OFF_RIS, 32'h0, "cleared");
        wr(OFF_CTL, 32'h1);
        wait_irq(n);
        chk32("oneshot again", 32'(n), 32'd7);
        wr(OFF_ICR, {23'h0, INT_USED});
        idle(1);
        chk32("no trigger", 32'(trig_cnt), 32'd1);
        $display("test joined oneshot done");
        // stall freezes, load write lands at once
        wr(OFF_CTL, 32'h3);
        wr(OFF_A_ILR, 32'h0ABC);
        idle(5);
        rd(OFF_A_VALUE, 32'h0ABC, "stalled value");
        wr(OFF_CTL, 32'h1);
        idle(20);
        wr(OFF_CTL, 32'h3);
        rd(OFF_A_VALUE, 32'h0AA7, "resumed value");
        wr(OFF_CTL, 32'h0);
        $display("test stall done");
        // split: b periodic with prescale 2, load 3
        wr(OFF_CFG, {29'h0, CFG_16});
        wr(OFF_A_ILR, 32'h5555_0123);
        rd(OFF_A_VALUE, 32'h0000_0123, "split a value");
        rd(OFF_B_VALUE, 32'h0, "split b value");
        wr(OFF_B_MODE, {30'h0, MODE_PERIODIC});
        wr(OFF_B_PR, 32'h2);
        wr(OFF_B_ILR, 32'h3);
        wr(OFF_IMR, 32'h100);
        wr(OFF_CTL, 32'h2100);
        idle(60);
        wr(OFF_CTL, 32'h0);
        chk32("period", 32'(trig_gap), 32'd12);
        rd(OFF_RIS, 32'h100, "b timeout");
        wr(OFF_ICR, {23'h0, INT_USED});
        rd(OFF_RIS, 32'h0, "b cleared");
        $display("test split done");
        // rtc selection loads one
        wr(OFF_CFG, {29'h0, CFG_32_RTC});
        rd(OFF_A_VALUE, 32'h1, "rtc first load");
        // match on the first second, with a stall bit under override
        wr(OFF_A_MATCH, 32'h1);
        wr(OFF_IMR, 32'h8);
        rtc_drive <= 1'b1;
        wr(OFF_CTL, 32'h13);
        wait_irq(n);
        rtc_drive <= 1'b0;
        chk32("rtc tick", 32'(n > 65529 && n < 65551), 32'h1);
        rd(OFF_RIS, 32'h8, "rtc raw match");
        rd(OFF_MIS, 32'h8, "rtc masked match");
        rd(OFF_A_VALUE, 32'h0, "rtc rollover");
        wr(OFF_ICR, 32'h8);
        rd(OFF_RIS, 32'h0, "rtc cleared");
        wr(OFF_CTL, 32'h0);
        $display("test rtc done");
        end_of_test();
    end
endmodule
